/* bench/burst_seat_pulse_failsafe_chk.sv */
// concurrent checks on the ports of the burst seat-clean block
`timescale 1ns/100ps
module burst_seat_pulse_failsafe_chk #(
   parameter int HANDSHAKE_CYCLES = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // valve side
   input wire logic [1:0] pneumatic_solenoid,
   input wire logic handshake_out,
   input wire logic handshake_led
);
   logic [31:0] hs_cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hs_cnt <= 32'h0;
      else
         hs_cnt <= handshake_out ? hs_cnt + 32'h1 : 32'h0;
   end
   property p_hs_len;
      $fell(handshake_out) |-> hs_cnt == 32'(HANDSHAKE_CYCLES);
   endproperty
   a_hs_len: assert property (p_hs_len) else $error("handshake length wrong");
   property p_hs_led;
      handshake_led == handshake_out;
   endproperty
   a_hs_led: assert property (p_hs_led) else $error("visual handshake differs");
   property p_release;
      $rose(handshake_out) |-> $past(pneumatic_solenoid) != 2'h0 && pneumatic_solenoid == 2'h0;
   endproperty
   a_release: assert property (p_release) else $error("handshake without release");
   property p_hs_quiet;
      handshake_out |-> pneumatic_solenoid == 2'h0;
   endproperty
   a_hs_quiet: assert property (p_hs_quiet) else $error("solenoid on in handshake");
   property p_ready;
      psel && !penable |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_ready_one;
      pready |=> !pready;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready held too long");
   property p_err;
      pslverr |-> pready && psel && penable;
   endproperty
   a_err: assert property (p_err) else $error("error outside access");
   property p_err_zero;
      pready && pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
   c_hs: cover property ($rose(handshake_out));
   c_lsp: cover property ($rose(pneumatic_solenoid[1]));
   c_err: cover property (pslverr);
endmodule

/* bench/burst_seat_pulse_failsafe_tb.sv */
// self-checking bench for the burst seat-clean and fail-safe block
`timescale 1ns/100ps
module burst_seat_pulse_failsafe_tb;
   import valve_top_pkg::*;
   localparam int HS = 20;
   localparam int MS = 4;
   localparam logic [31:0] CFGS [5] = '{32'h95, 32'h16, 32'h9A, 32'h97, 32'h96};
   localparam logic [31:0] ENS [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_WIDTH-1:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, position_reached, handshake_out, handshake_led;
   logic valve_state, status_error, irq, er, ex;
   logic upper_seat_lift_request = 1'b0;
   logic lower_seat_push_request = 1'b0;
   logic select_button = 1'b0;
   logic enter_button = 1'b0;
   logic [1:0] pneumatic_solenoid;
   logic [3:0] menu_indicator;
   logic [15:0] travel = 16'h28;
   logic [31:0] rd;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;
   int n;
   always #2 pclk = ~pclk;
   burst_seat_pulse_failsafe #(.HANDSHAKE_CYCLES(HS), .MS_CYCLES(MS)) u_dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .upper_seat_lift_request, .lower_seat_push_request, .position_reached, .select_button,
      .enter_button, .pneumatic_solenoid, .handshake_out, .handshake_led, .menu_indicator,
      .valve_state, .status_error, .irq);
   valve_stem_model u_stem (.pclk, .presetn, .pneumatic_solenoid, .travel, .position_reached);
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", s, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(s, rd, e);
   endtask
   task automatic press(input logic ent);
      if (ent)
         enter_button <= 1'b1;
      else
         select_button <= 1'b1;
      repeat (8) @(posedge pclk);
      enter_button <= 1'b0;
      select_button <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test;
      end
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("valve", valve_state, 32'h1);
      rdc("ctrl", ADDR_CTRL, 32'h0);
      rdc("config", ADDR_CONFIG, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", er, 32'h1);
      chk("unmapped", rd, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, ADDR_CONFIG, CFGS[i]);
         apb(1'b1, ADDR_CTRL, 32'h1);
         rdc("enable", ADDR_CTRL, ENS[i]);
      end
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("restore", rd[0], 32'h0);
      repeat (3) press(1'b0);
      press(1'b1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("three selects", rd[0], 32'h0);
      repeat (4) press(1'b0);
      chk("menu", menu_indicator, 32'h4);
      press(1'b1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("toggle on", rd[0], 32'h1);
      rdc("status", ADDR_STATUS, 32'h51);
      apb(1'b1, ADDR_INT_MASK, 32'h1);
      upper_seat_lift_request <= 1'b1;
      while (pneumatic_solenoid === 2'h0) @(posedge pclk);
      chk("usl solenoid", pneumatic_solenoid, 32'h1);
      while (handshake_out !== 1'b1) @(posedge pclk);
      chk("released", pneumatic_solenoid, 32'h0);
      n = 0;
      while (handshake_out === 1'b1)
      begin
         n++;
         if (n == 3)
            chk("irq", irq, 32'h1);
         @(posedge pclk);
      end
      chk("handshake len", n, HS);
      rdc("int", ADDR_INT_STATUS, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", irq, 32'h0);
      // request stays up at least 500 ms in all
      repeat (REQ_MIN_MS * MS) @(posedge pclk);
      upper_seat_lift_request <= 1'b0;
      travel <= 16'h5;
      apb(1'b1, ADDR_INT_MASK, 32'h0);
      apb(1'b1, ADDR_STROKE, 32'h2);
      apb(1'b1, ADDR_CONFIG, 32'h86);
      lower_seat_push_request <= 1'b1;
      while (pneumatic_solenoid === 2'h0) @(posedge pclk);
      chk("lsp solenoid", pneumatic_solenoid, 32'h2);
      n = 0;
      while (pneumatic_solenoid === 2'h2)
      begin
         n++;
         @(posedge pclk);
      end
      ex = n >= (2 + LSP_MARGIN_MS) * MS && n <= (2 + LSP_MARGIN_MS) * MS + 4;
      chk("timed pulse", ex, 32'h1);
      chk("timed handshake", handshake_out, 32'h1);
      chk("masked irq", irq, 32'h0);
      repeat (REQ_MIN_MS * MS) @(posedge pclk);
      lower_seat_push_request <= 1'b0;
      rdc("int timed", ADDR_INT_STATUS, 32'h3);
      repeat (4) press(1'b0);
      press(1'b1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("toggle off", rd[0], 32'h0);
      // digital with auto setup, as-interface, io-link with live setup
      for (int v = 0; v < 3; v++)
      begin
         apb(1'b1, ADDR_CONFIG, (v == 2) ? 32'hCA : (v == 1) ? 32'hB6 : 32'h96);
         for (int c = 15; c < 32; c++)
         begin
            apb(1'b1, ADDR_ERRORS, 32'h1 << c);
            repeat (2) @(posedge pclk);
            ex = !(c inside {16, [19:22], 31} || (v != 1 && c inside {[23:27], 29, 30}));
            chk("valve state", valve_state, ex);
         end
      end
      rdc("int fail", ADDR_INT_STATUS, 32'h4);
      apb(1'b1, ADDR_ERRORS, 32'h0);
      repeat (2) @(posedge pclk);
      chk("valve back", valve_state, 32'h1);
      apb(1'b1, ADDR_CONFIG, 32'h9E);
      apb(1'b1, ADDR_ERRORS, 32'h1_0000);
      repeat (2) @(posedge pclk);
      chk("flex valve", valve_state, 32'h1);
      chk("flex status", status_error, 32'h1);
      finish_test;
   end
endmodule
bind burst_seat_pulse_failsafe burst_seat_pulse_failsafe_chk #(
   .HANDSHAKE_CYCLES(HANDSHAKE_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pneumatic_solenoid(pneumatic_solenoid), .handshake_out(handshake_out),
   .handshake_led(handshake_led));

/* bench/valve_stem_model.sv */
// valve stem model: sensor reports the energised position after a travel delay
`timescale 1ns/100ps
module valve_stem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // solenoid drive, travel time in cycles, position sensor
   input wire logic [1:0] pneumatic_solenoid,
   input wire logic [15:0] travel,
   output logic position_reached
);
   logic [15:0] cnt;
   // stem falls back at once when the solenoid drops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= 16'h0;
         position_reached <= 1'b0;
      end
      else
      begin
         cnt <= (pneumatic_solenoid != 2'h0) ? cnt + 16'h1 : 16'h0;
         position_reached <= (pneumatic_solenoid != 2'h0) && (cnt >= travel);
      end
   end
endmodule

/* rtl/burst_seat_pulse_failsafe.sv */
// burst seat-clean sequencer and fail-safe valve state with an apb register file
`timescale 1ns/100ps
module burst_seat_pulse_failsafe #(
   parameter int HANDSHAKE_CYCLES = valve_top_pkg::HANDSHAKE_CYCLES_DEF,
   parameter int MS_CYCLES = valve_top_pkg::MS_CYCLES_DEF,
   parameter int STROKE_WIDTH = valve_top_pkg::STROKE_WIDTH_DEF
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [valve_top_pkg::ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // controller requests, sensor and buttons
   input wire logic upper_seat_lift_request,
   input wire logic lower_seat_push_request,
   input wire logic position_reached,
   input wire logic select_button,
   input wire logic enter_button,
   // valve and controller outputs
   output logic [1:0] pneumatic_solenoid,
   output logic handshake_out,
   output logic handshake_led,
   output logic [3:0] menu_indicator,
   output logic valve_state,
   output logic status_error,
   output logic irq
);
   import valve_top_pkg::*;

   logic [PIN_COUNT-1:0] pins;
   logic [PIN_COUNT-1:0] pins_prev;
   logic usl_s;
   logic lsp_s;
   logic pos_s;
   logic usl_rise;
   logic lsp_rise;
   logic select_rise;
   logic enter_rise;
   logic burst_enable;
   config_type cfg;
   logic [31:0] errors;
   logic [STROKE_WIDTH-1:0] stroke_ms;
   logic [INT_WIDTH-1:0] int_status;
   logic [INT_WIDTH-1:0] int_mask;
   logic [INT_WIDTH-1:0] int_events;
   state_type state;
   logic pulse_lsp;
   logic [31:0] ms_div;
   logic [STROKE_WIDTH:0] ms_count;
   logic [31:0] hs_count;
   logic burst_allowed;
   logic timed_mode;
   logic [STROKE_WIDTH:0] pulse_limit;
   logic pulse_release;
   logic monitored;
   logic next_valve_state;
   logic setup_phase;
   logic wr_access;
   logic rd_access;
   logic addr_mapped;
   logic [31:0] rd_mux;

   if (HANDSHAKE_CYCLES < 1 || MS_CYCLES < 1 || STROKE_WIDTH < 1 || STROKE_WIDTH > 31)
   begin : g_bad_params
      $error("burst_seat_pulse_failsafe parameters out of range");
   end

   pin_sync #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({enter_button, select_button, position_reached, lower_seat_push_request,
         upper_seat_lift_request}),
      .sync_out(pins)
   );

   assign usl_s = pins[0];
   assign lsp_s = pins[1];
   assign pos_s = pins[2];
   assign usl_rise = pins[0] & ~pins_prev[0];
   assign lsp_rise = pins[1] & ~pins_prev[1];
   assign select_rise = pins[3] & ~pins_prev[3];
   assign enter_rise = pins[4] & ~pins_prev[4];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pins_prev <= '0;
      else
         pins_prev <= pins;
   end

   // apb: setup cycle prepares the answer, access phase lasts one cycle
   assign setup_phase = psel & ~penable;
   assign wr_access = psel & penable & pready & pwrite;
   assign rd_access = psel & penable & pready & ~pwrite;

   always_comb
   begin
      addr_mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         ADDR_CTRL: rd_mux[CTRL_ENABLE_BIT] = burst_enable;
         ADDR_CONFIG: rd_mux[$bits(config_type)-1:0] = cfg;
         ADDR_ERRORS: rd_mux = errors;
         ADDR_STROKE: rd_mux[STROKE_WIDTH-1:0] = stroke_ms;
         ADDR_STATUS: rd_mux[12:0] = {menu_indicator, state, status_error, valve_state,
            handshake_out, pneumatic_solenoid, burst_enable};
         ADDR_INT_STATUS: rd_mux[INT_WIDTH-1:0] = int_status;
         ADDR_INT_MASK: rd_mux[INT_WIDTH-1:0] = int_mask;
         default: addr_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~addr_mapped;
         if (setup_phase && !pwrite)
            prdata <= rd_mux;
         else if (setup_phase)
            prdata <= 32'h0000_0000;
      end
   end

   // configuration written by the setup software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= CONFIG_RESET;
         errors <= ERRORS_RESET;
         stroke_ms <= '0;
         int_mask <= '0;
      end
      else if (wr_access)
      begin
         case (paddr)
            ADDR_CONFIG: cfg <= pwdata[$bits(config_type)-1:0];
            ADDR_ERRORS: errors <= pwdata;
            ADDR_STROKE: stroke_ms <= pwdata[STROKE_WIDTH-1:0];
            ADDR_INT_MASK: int_mask <= pwdata[INT_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   assign burst_allowed = cfg.setup_ok && cfg.kind == KIND_AUTO &&
      (cfg.solenoids == MIN_SOLENOIDS || cfg.solenoids == MAX_SOLENOIDS);

   // burst enable: menu toggle, remote parameter, factory restore
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         burst_enable <= 1'b0;
      else if (!burst_allowed)
         burst_enable <= 1'b0;
      else if (wr_access && paddr == ADDR_CTRL && pwdata[CTRL_RESTORE_BIT])
         burst_enable <= 1'b0;
      else if (wr_access && paddr == ADDR_CTRL)
         burst_enable <= pwdata[CTRL_ENABLE_BIT];
      else if (enter_rise && menu_indicator == MENU_BURST)
         burst_enable <= ~burst_enable;
   end

   // button menu position shown on the indicators
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         menu_indicator <= 4'h0;
      else if (enter_rise)
         menu_indicator <= 4'h0;
      else if (select_rise && menu_indicator == MENU_LAST)
         menu_indicator <= 4'h0;
      else if (select_rise)
         menu_indicator <= menu_indicator + 4'h1;
   end

   // pulse release: stem position, or stroke time plus margin without the upper sensor
   assign timed_mode = ~cfg.upper_sensor;
   assign pulse_limit = {1'b0, stroke_ms} + (STROKE_WIDTH + 1)'(LSP_MARGIN_MS);
   assign pulse_release = timed_mode ? (ms_count >= pulse_limit) : pos_s;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         pulse_lsp <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
               if (burst_enable && (usl_rise || lsp_rise))
               begin
                  state <= ST_PULSE;
                  pulse_lsp <= ~usl_rise;
               end
            ST_PULSE:
               if (!burst_enable)
                  state <= ST_IDLE;
               else if (pulse_release)
                  state <= ST_HANDSHAKE;
            ST_HANDSHAKE:
               if (hs_count == 32'h0000_0001)
                  state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // millisecond base for the timed pulse
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_div <= 32'h0000_0000;
         ms_count <= '0;
      end
      else if (state != ST_PULSE)
      begin
         ms_div <= 32'h0000_0000;
         ms_count <= '0;
      end
      else if (ms_div == 32'(MS_CYCLES - 1))
      begin
         ms_div <= 32'h0000_0000;
         if (ms_count != '1)
            ms_count <= ms_count + 1'b1;
      end
      else
         ms_div <= ms_div + 32'h0000_0001;
   end

   // handshake length counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hs_count <= 32'h0000_0000;
      else if (state == ST_PULSE && burst_enable && pulse_release)
         hs_count <= 32'(HANDSHAKE_CYCLES);
      else if (hs_count != 32'h0000_0000)
         hs_count <= hs_count - 32'h0000_0001;
   end

   // solenoids follow the requests directly while burst mode is off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pneumatic_solenoid <= 2'h0;
         handshake_out <= 1'b0;
         handshake_led <= 1'b0;
      end
      else
      begin
         if (!burst_enable)
            pneumatic_solenoid <= {lsp_s, usl_s};
         else if (state == ST_IDLE && (usl_rise || lsp_rise))
            pneumatic_solenoid <= {~usl_rise, usl_rise};
         else if (state == ST_PULSE && !pulse_release)
            pneumatic_solenoid <= {pulse_lsp, ~pulse_lsp};
         else
            pneumatic_solenoid <= 2'h0;
         handshake_out <= (state == ST_PULSE && burst_enable && pulse_release) ||
            (state == ST_HANDSHAKE && hs_count != 32'h0000_0001);
         handshake_led <= (state == ST_PULSE && burst_enable && pulse_release) ||
            (state == ST_HANDSHAKE && hs_count != 32'h0000_0001);
      end
   end

   // fail-safe valve state; codes outside both masks are ignored
   assign monitored = cfg.setup_ok && (cfg.kind == KIND_AUTO || cfg.kind == KIND_LIVE);
   assign next_valve_state = ~(monitored && ((|(errors & ERR_ALL_MASK)) ||
      (cfg.variant != VAR_ASI && (|(errors & ERR_WIRED_MASK)))));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         valve_state <= 1'b1;
         status_error <= 1'b0;
      end
      else
      begin
         valve_state <= next_valve_state;
         status_error <= cfg.kind == KIND_FLEX && (|errors);
      end
   end

   // sticky interrupt causes, cleared by reading; a new event wins over the clear
   assign int_events[INT_DONE_BIT] = state == ST_PULSE && burst_enable && pulse_release;
   assign int_events[INT_TIMED_BIT] = int_events[INT_DONE_BIT] && timed_mode;
   assign int_events[INT_FAIL_BIT] = valve_state && !next_valve_state;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         int_status <= '0;
      else if (rd_access && paddr == ADDR_INT_STATUS)
         int_status <= int_events;
      else
         int_status <= int_status | int_events;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(int_status & int_mask);
   end
endmodule

/* rtl/pin_sync.sv */
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins and clean levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("pin_sync needs at least one bit");
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_out <= '0;
      else
         for (int i = 0; i < WIDTH; i++)
            if (stage2[i] == stage3[i])
               sync_out[i] <= stage3[i];
   end
endmodule

/* rtl/valve_top_pkg.sv */
// constants, types and register map of the burst seat-clean and fail-safe block
//
// Overview of operation
// - burst seat-clean may be enabled only with 2 or 3 solenoids and after a good auto setup.
// - four select presses then enter toggle burst seat-clean between enabled and disabled.
// - the burst enable is also a parameter that software can write remotely.
// - burst mode is off after reset, and a factory restore clears it even when it was on.
// - with burst mode on, a seat lift or seat push request energises the matching solenoid.
// - the pulsing solenoid drops as soon as the stem reaches its energised position.
// - a finished pulse raises an electrical and a visual handshake for at least 2 s.
// - without the upper seat sensor the pulse lasts the stored seat push stroke plus a margin.
// - codes 16, 19, 20, 21, 22 and 31 pull valve state low on every variant.
// - codes 23 to 27, 29 and 30 pull valve state low except on the AS-Interface variant.
// - codes 15, 17, 18 and 28 never change valve state.
// - valve state is made locally; the AS-Interface variant carries a de-energised signal.
// - valve state works after auto or live setup; flex setup reports a plain status error.
package valve_top_pkg;
   localparam int ADDR_WIDTH = 8;
   localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_WIDTH-1:0] ADDR_CONFIG = 8'h04;
   localparam logic [ADDR_WIDTH-1:0] ADDR_ERRORS = 8'h08;
   localparam logic [ADDR_WIDTH-1:0] ADDR_STROKE = 8'h0C;
   localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 8'h10;
   localparam logic [ADDR_WIDTH-1:0] ADDR_INT_STATUS = 8'h14;
   localparam logic [ADDR_WIDTH-1:0] ADDR_INT_MASK = 8'h18;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_RESTORE_BIT = 1;
   localparam int INT_WIDTH = 3;
   localparam int INT_DONE_BIT = 0;
   localparam int INT_TIMED_BIT = 1;
   localparam int INT_FAIL_BIT = 2;
   localparam logic [31:0] ERR_ALL_MASK = 32'h8079_0000;
   localparam logic [31:0] ERR_WIRED_MASK = 32'h6F80_0000;
   localparam logic [31:0] ERRORS_RESET = 32'h0000_0000;
   localparam logic [1:0] MIN_SOLENOIDS = 2'h2;
   localparam logic [1:0] MAX_SOLENOIDS = 2'h3;
   localparam logic [3:0] MENU_BURST = 4'h4;
   localparam logic [3:0] MENU_LAST = 4'h8;
   localparam longint CLK_HZ = 250_000_000;
   localparam longint HANDSHAKE_S = 2;
   localparam longint REQ_MIN_MS = 500;
   localparam longint MS_PER_S = 1000;
   localparam int HANDSHAKE_CYCLES_DEF = int'(HANDSHAKE_S * CLK_HZ);
   localparam int MS_CYCLES_DEF = int'(CLK_HZ / MS_PER_S);
   localparam int STROKE_WIDTH_DEF = 16;
   localparam int LSP_MARGIN_MS = 100;
   localparam int PIN_COUNT = 5;
   typedef enum logic [1:0] {KIND_NONE = 2'h0, KIND_AUTO = 2'h1, KIND_LIVE = 2'h2,
      KIND_FLEX = 2'h3} setup_kind_type;
   typedef enum logic [1:0] {VAR_DIGITAL = 2'h0, VAR_ASI = 2'h1, VAR_IOLINK = 2'h2,
      VAR_SPARE = 2'h3} variant_type;
   typedef struct packed {
      logic setup_ok;
      variant_type variant;
      logic upper_sensor;
      setup_kind_type kind;
      logic [1:0] solenoids;
   } config_type;
   localparam config_type CONFIG_RESET = 8'h00;
   typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_PULSE = 3'h2, ST_HANDSHAKE = 3'h4} state_type;
endpackage
